// >>> hdl/bfbi_pkg.sv
// Constants, field layouts and types shared by the burst flash bus interface.
package bfbi_pkg;
  localparam int          ADDR_W          = 18;
  localparam int          DATA_W          = 32;
  localparam int          CMD_W           = 8;
  localparam int          LAT_W           = 4;
  localparam int          OVL_BYTES       = 32768;
  localparam int          OVL_WORDS       = OVL_BYTES / 4;
  localparam int          SYNC_STAGES     = 2;
  localparam int          AXI_ADDR_W      = 8;

  localparam logic [7:0]  CMD_READ_ARRAY  = 8'hFF;
  localparam logic [7:0]  CMD_PROGRAM     = 8'h40;
  localparam logic [7:0]  CMD_OVERLAY_OFF = 8'hC0;

  localparam logic [7:0]  CTRL_OFS        = 8'h00;
  localparam logic [7:0]  STAT_OFS        = 8'h04;
  localparam int          CTRL_SYNC_BIT   = 0;
  localparam int          CTRL_XLAT_LSB   = 4;
  localparam int          CTRL_YLAT_LSB   = 8;
  localparam logic [31:0] CTRL_RST        = 32'h0000_0131;
  localparam int          STAT_OVL_BIT    = 0;
  localparam int          STAT_PD_BIT     = 1;
  localparam int          STAT_BURST_BIT  = 2;
  localparam int          STAT_PROG_BIT   = 3;
  localparam int          STAT_CMD_LSB    = 8;

  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;
  localparam logic [3:0]  LAT_RST         = 4'h0;

  typedef struct packed {
    logic link_clk;
    logic chip_enable_n;
    logic output_enable_n;
    logic write_enable_n;
    logic latch_burst_addr_n;
    logic direction_select;
    logic burst_address_advance_n;
    logic output_disable_n;
    logic reset_powerdown_n;
  } bfbi_ctl_s;

  localparam bfbi_ctl_s CTL_IDLE = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

  typedef enum logic [2:0] {
    BS_IDLE = 3'b001,
    BS_WAIT = 3'b010,
    BS_DATA = 3'b100
  } bfbi_burst_e;

  typedef enum logic [1:0] {
    CS_READ = 2'b01,
    CS_PROG = 2'b10
  } bfbi_cmd_e;
endpackage

// >>> hdl/bfbi_flash.sv
// Device-side logic of the burst flash bus interface with its AXI4-Lite register slave.
// What this block does
// - A burst read starts on a link clock rise with enable, latch and read.
// - In synchronous mode, data is driven only after the first-access latency, with output enable low.
// - With advance low, the burst address steps after each per-beat latency.
// - Only full 32-bit words are programmed into the flash; reads return full words.
// - Commands come from the low eight data lines; upper lines are ignored.
// - Reset-powerdown high is normal; low during host reset gives read mode.
// - Reset-powerdown low means low power; rising again restores the reset state, all but the last command kept in status.
// - After reset the 32 Kbyte overlay replaces block 0 until disabled.
// - Asynchronous mode ignores link clock, latch, direction and advance pins.
// - Host fetches byte 100h after reset, seen as word 40h here.
// - Big-endian hosts reverse address and data bit order between parts.
// - Output disable has a pull-up; when high, other strobes control outputs.
module bfbi_flash #(
  parameter int ADDR_W    = bfbi_pkg::ADDR_W,
  parameter int OVL_WORDS = bfbi_pkg::OVL_WORDS
) (
  input  wire logic                              clk_i,
  input  wire logic                              rst_n_i,
  input  wire bfbi_pkg::bfbi_ctl_s               flash_ctl_i,
  input  wire logic [ADDR_W-1:0]                 flash_addr_i,
  input  wire logic [bfbi_pkg::DATA_W-1:0]       flash_dq_i,
  output logic      [bfbi_pkg::DATA_W-1:0]       flash_dq_o,
  output logic                                   flash_dq_oe_o,
  input  wire logic [bfbi_pkg::AXI_ADDR_W-1:0]   s_axi_awaddr_i,
  input  wire logic                              s_axi_awvalid_i,
  output logic                                   s_axi_awready_o,
  input  wire logic [31:0]                       s_axi_wdata_i,
  input  wire logic [3:0]                        s_axi_wstrb_i,
  input  wire logic                              s_axi_wvalid_i,
  output logic                                   s_axi_wready_o,
  output logic      [1:0]                        s_axi_bresp_o,
  output logic                                   s_axi_bvalid_o,
  input  wire logic                              s_axi_bready_i,
  input  wire logic [bfbi_pkg::AXI_ADDR_W-1:0]   s_axi_araddr_i,
  input  wire logic                              s_axi_arvalid_i,
  output logic                                   s_axi_arready_o,
  output logic      [31:0]                       s_axi_rdata_o,
  output logic      [1:0]                        s_axi_rresp_o,
  output logic                                   s_axi_rvalid_o,
  input  wire logic                              s_axi_rready_i
);
  localparam int SW = $bits(bfbi_pkg::bfbi_ctl_s) + ADDR_W + bfbi_pkg::DATA_W;

  // Word-aligned register decode.
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    reg_hit = (addr[7:2] == ofs[7:2]);
  endfunction

  // Pin synchroniser: two stages, plus one history stage for edge finding.
  logic [SW-1:0]             sync_q [bfbi_pkg::SYNC_STAGES];
  bfbi_pkg::bfbi_ctl_s       ctl;
  bfbi_pkg::bfbi_ctl_s       ctl_prev;
  logic [ADDR_W-1:0]         pin_addr;
  logic [bfbi_pkg::DATA_W-1:0] pin_dq;

  genvar g;
  for (g = 0; g < bfbi_pkg::SYNC_STAGES; g++) begin : g_sync
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        sync_q[g] <= {bfbi_pkg::CTL_IDLE, {(ADDR_W + bfbi_pkg::DATA_W){1'b0}}};
      end else if (g == 0) begin
        sync_q[g] <= {flash_ctl_i, flash_addr_i, flash_dq_i};
      end else begin
        sync_q[g] <= sync_q[(g == 0) ? 0 : g - 1];
      end
    end
  end

  assign {ctl, pin_addr, pin_dq} = sync_q[bfbi_pkg::SYNC_STAGES-1];

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctl_prev <= bfbi_pkg::CTL_IDLE;
    end else begin
      ctl_prev <= ctl;
    end
  end

  logic link_rise;
  logic write_rise;
  logic powered_down;
  assign link_rise    = ctl.link_clk & ~ctl_prev.link_clk;
  assign write_rise   = ctl.write_enable_n & ~ctl_prev.write_enable_n & ~ctl.chip_enable_n;
  assign powered_down = ~ctl.reset_powerdown_n;

  // Control register fields.
  logic [31:0]               ctrl;
  logic                      sync_en;
  logic [bfbi_pkg::LAT_W-1:0] x_lat;
  logic [bfbi_pkg::LAT_W-1:0] y_lat;
  assign sync_en = ctrl[bfbi_pkg::CTRL_SYNC_BIT];
  assign x_lat   = ctrl[bfbi_pkg::CTRL_XLAT_LSB +: bfbi_pkg::LAT_W];
  assign y_lat   = ctrl[bfbi_pkg::CTRL_YLAT_LSB +: bfbi_pkg::LAT_W];

  // Burst read sequencer.
  bfbi_pkg::bfbi_burst_e      bstate, next_bstate;
  logic [ADDR_W-1:0]          baddr, next_baddr;
  logic [bfbi_pkg::LAT_W-1:0] lat_cnt, next_lat_cnt;

  always_comb begin
    next_bstate  = bstate;
    next_baddr   = baddr;
    next_lat_cnt = lat_cnt;
    if (powered_down || !sync_en || ctl.chip_enable_n) begin
      next_bstate  = bfbi_pkg::BS_IDLE;
      next_lat_cnt = bfbi_pkg::LAT_RST;
    end else if (link_rise && !ctl.latch_burst_addr_n && ctl.direction_select) begin
      next_baddr   = pin_addr;
      next_lat_cnt = 4'h1;
      next_bstate  = (x_lat <= 4'h1) ? bfbi_pkg::BS_DATA : bfbi_pkg::BS_WAIT;
    end else if (link_rise) begin
      unique case (bstate)
        bfbi_pkg::BS_IDLE: begin
          next_bstate = bfbi_pkg::BS_IDLE;
        end
        bfbi_pkg::BS_WAIT: begin
          next_lat_cnt = lat_cnt + 4'h1;
          if (lat_cnt + 4'h1 >= x_lat) begin
            next_bstate  = bfbi_pkg::BS_DATA;
            next_lat_cnt = bfbi_pkg::LAT_RST;
          end
        end
        bfbi_pkg::BS_DATA: begin
          if (!ctl.burst_address_advance_n) begin
            next_lat_cnt = lat_cnt + 4'h1;
            if (lat_cnt + 4'h1 >= y_lat) begin
              next_baddr   = baddr + {{(ADDR_W-1){1'b0}}, 1'b1};
              next_lat_cnt = bfbi_pkg::LAT_RST;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bstate  <= bfbi_pkg::BS_IDLE;
      baddr   <= '0;
      lat_cnt <= bfbi_pkg::LAT_RST;
    end else begin
      bstate  <= next_bstate;
      baddr   <= next_baddr;
      lat_cnt <= next_lat_cnt;
    end
  end

  // Command interface and overlay selection.
  bfbi_pkg::bfbi_cmd_e    cstate, next_cstate;
  logic                   overlay_on, next_overlay_on;
  logic [bfbi_pkg::CMD_W-1:0] last_cmd, next_last_cmd;
  logic                   prog_we;

  always_comb begin
    next_cstate     = cstate;
    next_overlay_on = overlay_on;
    next_last_cmd   = last_cmd;
    prog_we         = 1'b0;
    if (powered_down) begin
      next_cstate     = bfbi_pkg::CS_READ;
      next_overlay_on = 1'b1;
    end else if (write_rise) begin
      unique case (cstate)
        bfbi_pkg::CS_PROG: begin
          prog_we     = 1'b1;
          next_cstate = bfbi_pkg::CS_READ;
        end
        bfbi_pkg::CS_READ: begin
          next_last_cmd = pin_dq[bfbi_pkg::CMD_W-1:0];
          if (pin_dq[bfbi_pkg::CMD_W-1:0] == bfbi_pkg::CMD_PROGRAM) begin
            next_cstate = bfbi_pkg::CS_PROG;
          end
          if (pin_dq[bfbi_pkg::CMD_W-1:0] == bfbi_pkg::CMD_OVERLAY_OFF) begin
            next_overlay_on = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cstate     <= bfbi_pkg::CS_READ;
      overlay_on <= 1'b1;
      last_cmd   <= bfbi_pkg::CMD_READ_ARRAY;
    end else begin
      cstate     <= next_cstate;
      overlay_on <= next_overlay_on;
      last_cmd   <= next_last_cmd;
    end
  end

  // Main array, overlay block and the data output path.
  logic [bfbi_pkg::DATA_W-1:0] main_mem [2**ADDR_W];
  logic [bfbi_pkg::DATA_W-1:0] ovl_mem  [OVL_WORDS];
  logic [ADDR_W-1:0]           rd_addr;
  logic                        rd_ovl;
  logic                        wr_ovl;
  logic                        next_drive;

  always_comb begin
    rd_addr    = sync_en ? baddr : pin_addr;
    rd_ovl     = overlay_on && (rd_addr < ADDR_W'(OVL_WORDS));
    wr_ovl     = overlay_on && (pin_addr < ADDR_W'(OVL_WORDS));
    next_drive = !powered_down && !ctl.chip_enable_n && !ctl.output_enable_n
               && ctl.output_disable_n && ctl.write_enable_n
               && (cstate == bfbi_pkg::CS_READ)
               && (!sync_en || bstate == bfbi_pkg::BS_DATA);
  end

  always_ff @(posedge clk_i) begin
    if (prog_we && wr_ovl) begin
      ovl_mem[pin_addr[$clog2(OVL_WORDS)-1:0]] <= pin_dq;
    end
    if (prog_we && !wr_ovl) begin
      main_mem[pin_addr] <= pin_dq;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flash_dq_o    <= '0;
      flash_dq_oe_o <= 1'b0;
    end else begin
      flash_dq_o    <= rd_ovl ? ovl_mem[rd_addr[$clog2(OVL_WORDS)-1:0]] : main_mem[rd_addr];
      flash_dq_oe_o <= next_drive;
    end
  end

  // AXI4-Lite register slave.
  logic        aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0]  aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic [31:0] next_ctrl, next_rdata, status;
  logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;

  always_comb begin
    status = '0;
    status[bfbi_pkg::STAT_OVL_BIT]   = overlay_on;
    status[bfbi_pkg::STAT_PD_BIT]    = powered_down;
    status[bfbi_pkg::STAT_BURST_BIT] = (bstate != bfbi_pkg::BS_IDLE);
    status[bfbi_pkg::STAT_PROG_BIT]  = (cstate == bfbi_pkg::CS_PROG);
    status[bfbi_pkg::STAT_CMD_LSB +: bfbi_pkg::CMD_W] = last_cmd;
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_ctrl    = ctrl;
    next_bvalid  = s_axi_bvalid_o && !s_axi_bready_i;
    next_bresp   = s_axi_bresp_o;
    next_rvalid  = s_axi_rvalid_o && !s_axi_rready_i;
    next_rdata   = s_axi_rdata_o;
    next_rresp   = s_axi_rresp_o;
    if (s_axi_awready_o && s_axi_awvalid_i) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wready_o && s_axi_wvalid_i) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata_i;
      next_w_strb = s_axi_wstrb_i;
    end
    if (aw_held && w_held && !s_axi_bvalid_o) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = bfbi_pkg::RESP_OKAY;
      if (reg_hit(aw_addr, bfbi_pkg::CTRL_OFS)) begin
        for (int b = 0; b < 4; b++) begin
          if (w_strb[b]) begin
            next_ctrl[8*b +: 8] = w_data[8*b +: 8];
          end
        end
      end else if (!reg_hit(aw_addr, bfbi_pkg::STAT_OFS)) begin
        next_bresp = bfbi_pkg::RESP_SLVERR;
      end
    end
    if (powered_down) begin
      next_ctrl = bfbi_pkg::CTRL_RST;
    end
    if (s_axi_arready_o && s_axi_arvalid_i) begin
      next_rvalid = 1'b1;
      next_rresp  = bfbi_pkg::RESP_OKAY;
      if (reg_hit(s_axi_araddr_i, bfbi_pkg::CTRL_OFS)) begin
        next_rdata = ctrl;
      end else if (reg_hit(s_axi_araddr_i, bfbi_pkg::STAT_OFS)) begin
        next_rdata = status;
      end else begin
        next_rdata = '0;
        next_rresp = bfbi_pkg::RESP_SLVERR;
      end
    end
    next_awready = !next_aw_held;
    next_wready  = !next_w_held;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      aw_held         <= 1'b0;
      aw_addr         <= '0;
      w_held          <= 1'b0;
      w_data          <= '0;
      w_strb          <= '0;
      ctrl            <= bfbi_pkg::CTRL_RST;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= bfbi_pkg::RESP_OKAY;
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= '0;
      s_axi_rresp_o   <= bfbi_pkg::RESP_OKAY;
    end else begin
      aw_held         <= next_aw_held;
      aw_addr         <= next_aw_addr;
      w_held          <= next_w_held;
      w_data          <= next_w_data;
      w_strb          <= next_w_strb;
      ctrl            <= next_ctrl;
      s_axi_awready_o <= next_awready;
      s_axi_wready_o  <= next_wready;
      s_axi_bvalid_o  <= next_bvalid;
      s_axi_bresp_o   <= next_bresp;
      s_axi_arready_o <= next_arready;
      s_axi_rvalid_o  <= next_rvalid;
      s_axi_rdata_o   <= next_rdata;
      s_axi_rresp_o   <= next_rresp;
    end
  end
endmodule

// >>> test/bfbi_chk.sv
// Concurrent checks on the ports of the flash interface.
module bfbi_chk (
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  input  wire bfbi_pkg::bfbi_ctl_s flash_ctl_i,
  input  wire logic                flash_dq_oe_o,
  input  wire logic [7:0]          s_axi_araddr_i,
  input  wire logic                s_axi_arvalid_i,
  input  wire logic                s_axi_arready_o,
  input  wire logic                s_axi_rvalid_o,
  input  wire logic                s_axi_rready_i,
  input  wire logic [31:0]         s_axi_rdata_o,
  input  wire logic [1:0]          s_axi_rresp_o,
  input  wire logic                s_axi_bvalid_o,
  input  wire logic                s_axi_bready_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  ce_high_float_a: assert property (flash_ctl_i.chip_enable_n [*6] |-> !flash_dq_oe_o)
    else $error("dq driven with chip enable high");
  oe_high_float_a: assert property (flash_ctl_i.output_enable_n [*6] |-> !flash_dq_oe_o)
    else $error("dq driven with output enable high");
  od_low_float_a: assert property (!flash_ctl_i.output_disable_n [*6] |-> !flash_dq_oe_o)
    else $error("dq driven with output disable low");
  pd_low_float_a: assert property (!flash_ctl_i.reset_powerdown_n [*6] |-> !flash_dq_oe_o)
    else $error("dq driven in power down");
  write_float_a: assert property (!flash_ctl_i.write_enable_n [*6] |-> !flash_dq_oe_o)
    else $error("dq driven during a write");
  rd_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read answer late");
  rd_release_a: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o && s_axi_arready_o)
    else $error("read not released");
  rd_unmapped_a: assert property (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i[7:3] != 5'h00
    |=> s_axi_rresp_o == bfbi_pkg::RESP_SLVERR && s_axi_rdata_o == 32'h0000_0000)
    else $error("unmapped read not refused");
  wr_release_a: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("write response not released");
  cover property (flash_dq_oe_o && !flash_ctl_i.burst_address_advance_n);
  cover property (s_axi_bvalid_o && s_axi_bready_i);
  cover property (s_axi_rvalid_o && s_axi_rresp_o == bfbi_pkg::RESP_SLVERR);
endmodule
bind bfbi_flash bfbi_chk i_bfbi_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .flash_ctl_i(flash_ctl_i),
  .flash_dq_oe_o(flash_dq_oe_o), .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i));

// >>> test/bfbi_host.sv
// Host bus model that drives the flash pins.
module bfbi_host (
  input  wire logic          clk_i,
  input  wire logic          oe_i,
  input  wire logic [31:0]   fdq_i,
  output bfbi_pkg::bfbi_ctl_s ctl_o,
  output logic      [17:0]   addr_o,
  output logic      [31:0]   dq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] bq [$];
  initial begin
    ctl_o = bfbi_pkg::CTL_IDLE;
    ctl_o.reset_powerdown_n = 1'h0;
    addr_o = 18'h0_0000;
    dq_o = 32'h0000_0000;
    #7;
    forever #24 ctl_o.link_clk = ~ctl_o.link_clk;
  end
  task automatic st();
    @(negedge ctl_o.link_clk);
    @(posedge clk_i);
  endtask
  task automatic rp(input logic v);
    ctl_o.reset_powerdown_n <= v;
  endtask
  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    ctl_o.chip_enable_n <= 1'h0;
    ctl_o.write_enable_n <= 1'h0;
    addr_o <= a;
    dq_o <= d;
    repeat (6) @(posedge clk_i);
    ctl_o.write_enable_n <= 1'h1;
    repeat (6) @(posedge clk_i);
    ctl_o.chip_enable_n <= 1'h1;
    dq_o <= ~d;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic rd(input logic [17:0] a, input logic od, input logic [31:0] r,
                    output logic [31:0] d, output logic s);
    ctl_o.chip_enable_n <= 1'h0;
    ctl_o.output_enable_n <= 1'h0;
    ctl_o.output_disable_n <= od;
    ctl_o.latch_burst_addr_n <= r[0];
    ctl_o.direction_select <= r[1];
    ctl_o.burst_address_advance_n <= r[2];
    addr_o <= a;
    s = 1'h0;
    for (int i = 0; i < 40 && !s; i++) begin
      @(posedge clk_i);
      s = oe_i;
    end
    repeat (6) @(posedge clk_i);
    d = fdq_i;
    ctl_o <= '{ctl_o.link_clk, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1};
    repeat (6) @(posedge clk_i);
  endtask
  task automatic burst(input logic [17:0] a, input int n);
    st();
    ctl_o.chip_enable_n <= 1'h0;
    ctl_o.output_enable_n <= 1'h0;
    ctl_o.latch_burst_addr_n <= 1'h0;
    ctl_o.direction_select <= 1'h1;
    addr_o <= a;
    @(posedge ctl_o.link_clk);
    st();
    ctl_o.latch_burst_addr_n <= 1'h1;
    addr_o <= ~a;
    repeat (2) @(posedge ctl_o.link_clk);
    st();
    ctl_o.burst_address_advance_n <= 1'h0;
    repeat (n) begin
      @(posedge ctl_o.link_clk);
      bq.push_back(fdq_i);
    end
    st();
    ctl_o <= '{ctl_o.link_clk, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1};
    @(posedge clk_i);
  endtask
endmodule

// >>> test/tb.sv
// Self-checking bench for the burst flash interface.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk_i = 1'h0;
  logic                rst_n_i = 1'h0;
  bfbi_pkg::bfbi_ctl_s ctl;
  logic [17:0]         fa;
  logic [31:0]         hdq, fdq, dq, rdata, d;
  logic [31:0]         wdata = 32'h0000_0000;
  logic [7:0]          awaddr = 8'h00, araddr = 8'h00;
  logic                awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic                oe, awready, wready, bvalid, arready, rvalid, s;
  logic [1:0]          bresp, rresp, r;
  int                  n_errors = 0, num_checks = 0;
  logic [31:0]         seed = 32'h0000_4916;
  logic [31:0]         m_main [int];
  logic [31:0]         m_ovl [int];
  bit                  ovl = 1'b1;
  always #2 clk_i = ~clk_i;
  assign fdq = oe ? dq : hdq;
  bfbi_host i_bfbi_host (.clk_i(clk_i), .oe_i(oe), .fdq_i(fdq), .ctl_o(ctl), .addr_o(fa), .dq_o(hdq));
  bfbi_flash i_bfbi_flash (.clk_i(clk_i), .rst_n_i(rst_n_i), .flash_ctl_i(ctl), .flash_addr_i(fa),
    .flash_dq_i(fdq), .flash_dq_o(dq), .flash_dq_oe_o(oe), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] ex(input int a);
    return (ovl && a < bfbi_pkg::OVL_WORDS) ? m_ovl[a] : m_main[a];
  endfunction
  task automatic conclude();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if ((g !== e) || $isunknown(e)) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    bit aw, w;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    forever begin
      @(posedge clk_i);
      if (!aw && !w && bvalid) break;
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'h0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'h0;
      end
    end
    rs = bresp;
    bready <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    bit ar;
    ar = 1'b1;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    forever begin
      @(posedge clk_i);
      if (!ar && rvalid) break;
      if (ar && arready) begin
        ar = 1'b0;
        arvalid <= 1'h0;
      end
    end
    v = rdata;
    rs = rresp;
    rready <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic cmd(input logic [7:0] c);
    d = xs();
    i_bfbi_host.wr(18'h0_0000, {d[31:8], c});
  endtask
  task automatic prog(input int a, input logic [31:0] v);
    cmd(bfbi_pkg::CMD_PROGRAM);
    i_bfbi_host.wr(18'(a), v);
    if (ovl && a < bfbi_pkg::OVL_WORDS) m_ovl[a] = v;
    else m_main[a] = v;
  endtask
  task automatic bst(input int a, input int n);
    i_bfbi_host.bq.delete();
    i_bfbi_host.burst(18'(a), n);
    for (int i = 0; i < n; i++) chk(i_bfbi_host.bq[i], ex(a + i));
  endtask
  task automatic ard(input int a);
    i_bfbi_host.rd(18'(a), 1'h1, xs(), d, s);
    chk(d, ex(a));
  endtask
  initial begin
    #200000;
    n_errors++;
    conclude();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'h1;
    i_bfbi_host.rp(1'h1);
    repeat (3) @(posedge clk_i);
    axr(bfbi_pkg::CTRL_OFS, d, r);
    chk(d, bfbi_pkg::CTRL_RST);
    axr(8'h08, d, r);
    chk({d[29:0], r}, {30'h0, bfbi_pkg::RESP_SLVERR});
    axw(8'h0C, 32'h0000_0000, r);
    chk({30'h0, r}, {30'h0, bfbi_pkg::RESP_SLVERR});
    axw(bfbi_pkg::STAT_OFS, 32'hFFFF_FFFF, r);
    chk({30'h0, r}, {30'h0, bfbi_pkg::RESP_OKAY});
    axr(bfbi_pkg::STAT_OFS, d, r);
    chk(d & 32'h0000_000B, 32'h0000_0001);
    for (int i = 0; i < 4; i++) prog(256 + i, xs());
    prog(64, xs());
    bst(256, 4);
    bst(64, 1);
    cmd(bfbi_pkg::CMD_OVERLAY_OFF);
    ovl = 1'b0;
    axr(bfbi_pkg::STAT_OFS, d, r);
    chk(d & 32'h0000_0001, 32'h0000_0000);
    for (int i = 0; i < 4; i++) prog(256 + i, xs());
    prog(64, xs());
    axw(bfbi_pkg::CTRL_OFS, 32'h0000_0130, r);
    chk({30'h0, r}, {30'h0, bfbi_pkg::RESP_OKAY});
    for (int i = 0; i < 4; i++) ard(256 + i);
    ard(64);
    i_bfbi_host.rd(18'h0_0040, 1'h0, xs(), d, s);
    chk({31'h0, s}, 32'h0000_0000);
    cmd(bfbi_pkg::CMD_READ_ARRAY);
    ard(257);
    i_bfbi_host.rp(1'h0);
    repeat (20) @(posedge clk_i);
    axr(bfbi_pkg::STAT_OFS, d, r);
    chk(d & 32'h0000_0002, 32'h0000_0002);
    i_bfbi_host.rp(1'h1);
    repeat (10) @(posedge clk_i);
    ovl = 1'b1;
    axr(bfbi_pkg::CTRL_OFS, d, r);
    chk(d, bfbi_pkg::CTRL_RST);
    bst(64, 1);
    conclude();
  end
endmodule
